// >>> design/sar_adc_config_window_compare.sv
// converter configuration registers, clock divider and window compare
// What this block does
// - power bit seven selects reduced bias mode
// - conversion clock is source over divider plus one
// - burst uses low power oscillator, else system clock
// - configuration bit two selects eight bit mode
// - normal tracking converts right after start
// - delayed tracking waits three conversion clocks
// - configuration bit zero selects half or unity gain
// - sixteen bit less-than bound, two bytes, reset zero
// - result is ten bit unsigned integer
// - inside compare: above greater, below less bound
// - outside compare: below lower or above upper
// - compare uses justified result word
// - eight bit converts eight msbs, two clocks sooner
// - eight bit low bits and low byte zero
`timescale 1ns/1ps
`include "sar_defs.svh"
module sar_adc_config_window_compare
(
  input  wire logic            core_clk_in,
  input  wire logic            reset_in,
  input  wire logic [7:0]      sfr_addr_in,
  input  wire logic [7:0]      sfr_wdata_in,
  input  wire logic            sfr_wr_in,
  input  wire logic            sfr_rd_in,
  input  wire logic            lfo_tick_in,
  input  wire logic            sar_cmp_in,
  output logic [7:0]           sfr_rdata_out,
  output logic                 low_power_out,
  output logic                 gain_unity_out,
  output logic                 tracking_out,
  output logic                 busy_out,
  output logic [9:0]           sar_trial_out,
  output logic                 conv_tick_out,
  output logic                 window_flag_out
);
  import sar_pkg::*;

  sar_pkg::config_s cfg;
  sar_pkg::config_s next_cfg;
  logic [7:0]  power_ctl;
  logic [7:0]  next_power_ctl;
  logic [15:0] lt_bound;
  logic [15:0] next_lt_bound;
  logic [15:0] gt_bound;
  logic [15:0] next_gt_bound;
  logic        enable;
  logic        next_enable;
  logic        outside_mode;
  logic        next_outside_mode;
  logic        left_justify;
  logic        next_left_justify;
  logic        burst;
  logic        next_burst;
  logic        flag;
  logic        next_flag;
  logic        start_pulse;
  logic        next_start_pulse;
  logic [7:0]  next_rdata;
  logic [4:0]  div_count;
  logic [4:0]  next_div_count;
  logic        next_conv_tick;
  logic        source_tick;
  logic [9:0]  result;
  logic        done;
  logic        core_busy;
  logic        core_tracking;
  logic [9:0]  core_trial;
  logic [15:0] result_word;
  logic        hit;

  // result word as software sees it, justification applied
  function automatic logic [15:0] justify(input logic [9:0] r, input logic left,
                                          input logic eight);
    logic [15:0] w;
    w = left ? {r, 6'h00} : {6'h00, r};
    if (eight)
      w = {r[9:2], 8'h00};
    return w;
  endfunction

  // writes to an unmapped address are dropped, reads of one return zero
  always_comb
  begin
    next_cfg          = cfg;
    next_power_ctl    = power_ctl;
    next_lt_bound     = lt_bound;
    next_gt_bound     = gt_bound;
    next_enable       = enable;
    next_outside_mode = outside_mode;
    next_left_justify = left_justify;
    next_burst        = burst;
    next_flag         = flag;
    next_start_pulse  = 1'b0;
    next_rdata        = sfr_rdata_out;
    if (sfr_wr_in)
    begin
      unique case (sfr_addr_in)
        `SAR_OFS_CONFIG:  next_cfg = sfr_wdata_in;
        `SAR_OFS_POWER:   next_power_ctl = {sfr_wdata_in[`SAR_POWER_LPM_BIT], 7'h00};
        `SAR_OFS_LT_LOW:  next_lt_bound[7:0] = sfr_wdata_in;
        `SAR_OFS_LT_HIGH: next_lt_bound[15:8] = sfr_wdata_in;
        `SAR_OFS_GT_LOW:  next_gt_bound[7:0] = sfr_wdata_in;
        `SAR_OFS_GT_HIGH: next_gt_bound[15:8] = sfr_wdata_in;
        `SAR_OFS_CONTROL:
        begin
          next_enable       = sfr_wdata_in[`SAR_CTL_ENABLE_BIT];
          next_outside_mode = sfr_wdata_in[`SAR_CTL_OUTSIDE_BIT];
          next_left_justify = sfr_wdata_in[`SAR_CTL_LEFT_BIT];
          next_burst        = sfr_wdata_in[`SAR_CTL_BURST_BIT];
          if (!sfr_wdata_in[`SAR_CTL_FLAG_BIT])
            next_flag = 1'b0;
          next_start_pulse  = sfr_wdata_in[`SAR_CTL_START_BIT] &
                              sfr_wdata_in[`SAR_CTL_ENABLE_BIT] & !core_busy;
        end
        default:
        begin
        end
      endcase
    end
    // set beats a clear written in the same cycle
    if (done && hit)
      next_flag = 1'b1;
    if (sfr_rd_in)
    begin
      unique case (sfr_addr_in)
        `SAR_OFS_CONFIG:      next_rdata = cfg;
        `SAR_OFS_POWER:       next_rdata = power_ctl;
        `SAR_OFS_LT_LOW:      next_rdata = lt_bound[7:0];
        `SAR_OFS_LT_HIGH:     next_rdata = lt_bound[15:8];
        `SAR_OFS_GT_LOW:      next_rdata = gt_bound[7:0];
        `SAR_OFS_GT_HIGH:     next_rdata = gt_bound[15:8];
        `SAR_OFS_RESULT_LOW:  next_rdata = result_word[7:0];
        `SAR_OFS_RESULT_HIGH: next_rdata = result_word[15:8];
        `SAR_OFS_CONTROL:     next_rdata = {enable, outside_mode, left_justify, burst,
                                            core_busy, flag, 2'b00};
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      cfg           <= `SAR_CONFIG_RESET;
      power_ctl     <= 8'h00;
      lt_bound      <= 16'h0000;
      gt_bound      <= 16'h0000;
      enable        <= 1'b0;
      outside_mode  <= 1'b0;
      left_justify  <= 1'b0;
      burst         <= 1'b0;
      flag          <= 1'b0;
      start_pulse   <= 1'b0;
      sfr_rdata_out <= 8'h00;
    end
    else
    begin
      cfg           <= next_cfg;
      power_ctl     <= next_power_ctl;
      lt_bound      <= next_lt_bound;
      gt_bound      <= next_gt_bound;
      enable        <= next_enable;
      outside_mode  <= next_outside_mode;
      left_justify  <= next_left_justify;
      burst         <= next_burst;
      flag          <= next_flag;
      start_pulse   <= next_start_pulse;
      sfr_rdata_out <= next_rdata;
    end
  end

  // divider counts source ticks; the system clock ticks every cycle
  always_comb
  begin
    source_tick    = burst ? lfo_tick_in : 1'b1;
    next_div_count = div_count;
    next_conv_tick = 1'b0;
    if (!enable)
      next_div_count = 5'h00;
    else if (source_tick)
    begin
      if (div_count >= cfg.clock_divider)
      begin
        next_div_count = 5'h00;
        next_conv_tick = 1'b1;
      end
      else
        next_div_count = div_count + 5'h01;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      div_count     <= 5'h00;
      conv_tick_out <= 1'b0;
    end
    else
    begin
      div_count     <= next_div_count;
      conv_tick_out <= next_conv_tick;
    end
  end

  sar_conv_core i_sar_conv_core
  (
    .core_clk_in   (core_clk_in),
    .reset_in      (reset_in),
    .conv_tick_in  (conv_tick_out),
    .start_in      (start_pulse),
    .track_mode_in (cfg.track_mode_select),
    .eight_bit_in  (cfg.eight_bit_resolution_enable),
    .cmp_in        (sar_cmp_in),
    .trial_out     (core_trial),
    .result_out    (result),
    .done_out      (done),
    .busy_out      (core_busy),
    .tracking_out  (core_tracking)
  );

  // compare the word that the finished conversion will leave in the result
  logic [15:0] done_word;
  always_comb
  begin
    result_word = justify(result, left_justify, cfg.eight_bit_resolution_enable);
    done_word   = justify(core_trial, left_justify, cfg.eight_bit_resolution_enable);
    if (outside_mode)
      hit = (done_word < gt_bound) || (done_word > lt_bound);
    else
      hit = (done_word > gt_bound) && (done_word < lt_bound);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      low_power_out   <= 1'b0;
      gain_unity_out  <= 1'b0;
      tracking_out    <= 1'b1;
      busy_out        <= 1'b0;
      sar_trial_out   <= 10'h000;
      window_flag_out <= 1'b0;
    end
    else
    begin
      low_power_out   <= power_ctl[`SAR_POWER_LPM_BIT];
      gain_unity_out  <= cfg.gain_select;
      tracking_out    <= core_tracking;
      busy_out        <= core_busy;
      sar_trial_out   <= core_trial;
      window_flag_out <= flag;
    end
  end
endmodule

// >>> design/sar_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH
`define SAR_OFS_CONFIG       8'hBC
`define SAR_OFS_LT_LOW       8'hC5
`define SAR_OFS_LT_HIGH      8'hC6
`define SAR_OFS_POWER        8'hBA
`define SAR_OFS_GT_LOW       8'hC3
`define SAR_OFS_GT_HIGH      8'hC4
`define SAR_OFS_RESULT_LOW   8'hBD
`define SAR_OFS_RESULT_HIGH  8'hBE
`define SAR_OFS_CONTROL      8'hE8
`define SAR_CONFIG_RESET     8'hF8
`define SAR_POWER_LPM_BIT    7
`define SAR_CTL_ENABLE_BIT   7
`define SAR_CTL_OUTSIDE_BIT  6
`define SAR_CTL_LEFT_BIT     5
`define SAR_CTL_BURST_BIT    4
`define SAR_CTL_BUSY_BIT     3
`define SAR_CTL_FLAG_BIT     2
`define SAR_CTL_START_BIT    0
`define SAR_TRACK_DELAY      2'd3
`define SAR_MSB_INDEX        4'd9
`define SAR_LSB_INDEX_10     4'd0
`define SAR_LSB_INDEX_8      4'd2
`endif

// >>> design/sar_pkg.sv
// types shared by the converter control files
package sar_pkg;
  typedef struct packed {
    logic [4:0] clock_divider;
    logic       eight_bit_resolution_enable;
    logic       track_mode_select;
    logic       gain_select;
  } config_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONV  = 2'b10
  } conv_state_e;
endpackage

// >>> design/sar_conv_core.sv
// successive approximation sequencer stepped by the conversion clock enable
`timescale 1ns/1ps
`include "sar_defs.svh"
module sar_conv_core
(
  input  wire logic            core_clk_in,
  input  wire logic            reset_in,
  input  wire logic            conv_tick_in,
  input  wire logic            start_in,
  input  wire logic            track_mode_in,
  input  wire logic            eight_bit_in,
  input  wire logic            cmp_in,
  output logic [9:0]           trial_out,
  output logic [9:0]           result_out,
  output logic                 done_out,
  output logic                 busy_out,
  output logic                 tracking_out
);
  import sar_pkg::*;

  conv_state_e state;
  conv_state_e next_state;
  logic [1:0]  delay;
  logic [1:0]  next_delay;
  logic [3:0]  index;
  logic [3:0]  next_index;
  logic [3:0]  last_index;
  logic [9:0]  next_trial;
  logic [9:0]  next_result;
  logic        next_done;

  always_comb
  begin
    next_state  = state;
    next_delay  = delay;
    next_index  = index;
    next_trial  = trial_out;
    next_result = result_out;
    next_done   = 1'b0;
    last_index  = eight_bit_in ? `SAR_LSB_INDEX_8 : `SAR_LSB_INDEX_10;
    unique case (state)
      ST_IDLE:
      begin
        if (start_in)
        begin
          next_index = `SAR_MSB_INDEX;
          next_trial = 10'h200;
          next_delay = 2'd0;
          next_state = track_mode_in ? ST_TRACK : ST_CONV;
        end
      end
      ST_TRACK:
      begin
        if (conv_tick_in)
        begin
          next_delay = delay + 2'd1;
          if (next_delay == `SAR_TRACK_DELAY)
            next_state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (conv_tick_in)
        begin
          if (!cmp_in)
            next_trial[index] = 1'b0;
          if (index == last_index)
          begin
            next_result = next_trial;
            next_done   = 1'b1;
            next_state  = ST_IDLE;
          end
          else
          begin
            next_index             = index - 4'd1;
            next_trial[next_index] = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      state        <= ST_IDLE;
      delay        <= 2'd0;
      index        <= 4'd0;
      trial_out    <= 10'h000;
      result_out   <= 10'h000;
      done_out     <= 1'b0;
      busy_out     <= 1'b0;
      tracking_out <= 1'b1;
    end
    else
    begin
      state        <= next_state;
      delay        <= next_delay;
      index        <= next_index;
      trial_out    <= next_trial;
      result_out   <= next_result;
      done_out     <= next_done;
      busy_out     <= (next_state != ST_IDLE);
      tracking_out <= (next_state != ST_CONV);
    end
  end
endmodule

// >>> bench/sar_adc_config_window_compare_asserts.sv
// assertion checker for the converter control block
`timescale 1ns/1ps
`include "sar_defs.svh"
module sar_adc_config_window_compare_asserts
(
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic       lfo_tick_in,
  input wire logic       sar_cmp_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       low_power_out,
  input wire logic       gain_unity_out,
  input wire logic       tracking_out,
  input wire logic       busy_out,
  input wire logic [9:0] sar_trial_out,
  input wire logic       conv_tick_out,
  input wire logic       window_flag_out
);
  logic [7:0] cfg;
  logic       burst;
  logic       armed;
  logic [5:0] gap;
  logic [3:0] ticks;
  logic       tick_d;
  logic       cfg_wr;
  logic       ctl_wr;
  logic       clr_wr;
  assign cfg_wr = sfr_wr_in && sfr_addr_in == `SAR_OFS_CONFIG;
  assign ctl_wr = sfr_wr_in && sfr_addr_in == `SAR_OFS_CONTROL;
  assign clr_wr = ctl_wr && !sfr_wdata_in[2];
  // divider phase is unknown after a config or control write, so the next gap is not judged
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      cfg   <= `SAR_CONFIG_RESET;
      burst <= 1'b0;
      armed <= 1'b0;
      gap   <= 6'h00;
      ticks <= 4'h0;
      tick_d <= 1'b0;
    end
    else
    begin
      cfg   <= cfg_wr ? sfr_wdata_in : cfg;
      burst <= ctl_wr ? sfr_wdata_in[4] : burst;
      armed <= !(cfg_wr || ctl_wr) && (armed || conv_tick_out);
      gap   <= conv_tick_out ? 6'h01 : gap + 6'h01;
      // busy output lags the sequencer by a cycle, so the tick is counted late too
      tick_d <= conv_tick_out;
      ticks <= busy_out ? ticks + {3'h0, tick_d} : 4'h0;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_cfg_settled;
    cfg_wr ##1 !cfg_wr ##1 !cfg_wr;
  endsequence
  sequence s_start;
    ctl_wr && sfr_wdata_in[7] && sfr_wdata_in[0] && !busy_out;
  endsequence
  a_tick_period: assert property (
    conv_tick_out && armed && !burst |-> gap == {1'b0, cfg[7:3]} + 6'h01)
    else $error("conversion clock period wrong");
  a_gain_follow: assert property (s_cfg_settled |-> gain_unity_out == cfg[0])
    else $error("gain output does not follow config");
  a_power_follow: assert property (
    sfr_wr_in && sfr_addr_in == `SAR_OFS_POWER |-> ##2 low_power_out == $past(sfr_wdata_in[7], 2))
    else $error("low power output does not follow write");
  a_conv_ticks: assert property (
    $fell(busy_out) |-> ticks == (cfg[2] ? 4'd8 : 4'd10) + (cfg[1] ? 4'd3 : 4'd0))
    else $error("conversion tick count wrong");
  a_start_track: assert property (
    s_start |-> ##3 (busy_out && tracking_out == cfg[1]))
    else $error("start did not enter the right phase");
  a_flag_sticky: assert property (
    window_flag_out && !clr_wr && !$past(clr_wr) |=> window_flag_out)
    else $error("window flag dropped without clear");
  a_flag_at_end: assert property (
    $rose(window_flag_out) |-> $past(busy_out) || $past(busy_out, 2))
    else $error("window flag rose outside conversion end");
  a_rdata_holds: assert property (!$past(sfr_rd_in) |-> $stable(sfr_rdata_out))
    else $error("read data changed without a read");
endmodule
bind sar_adc_config_window_compare sar_adc_config_window_compare_asserts
  i_sar_adc_config_window_compare_asserts
(
  .core_clk_in, .reset_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in,
  .lfo_tick_in, .sar_cmp_in, .sfr_rdata_out, .low_power_out, .gain_unity_out,
  .tracking_out, .busy_out, .sar_trial_out, .conv_tick_out, .window_flag_out
);

// >>> bench/sar_adc_config_window_compare_test.sv
// self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "sar_defs.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module sar_adc_config_window_compare_test;
  logic        core_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  sfr_addr_in = 8'h00;
  logic [7:0]  sfr_wdata_in = 8'h00;
  logic        sfr_wr_in = 1'b0;
  logic        sfr_rd_in = 1'b0;
  logic        lfo_tick_in = 1'b0;
  logic        sar_cmp_in = 1'b0;
  logic [7:0]  sfr_rdata_out;
  logic        low_power_out;
  logic        gain_unity_out;
  logic        tracking_out;
  logic        busy_out;
  logic [9:0]  sar_trial_out;
  logic        conv_tick_out;
  logic        window_flag_out;
  int          num_errors = 0;
  int          n_checks = 0;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp_v;
  logic        rd_seen = 1'b0;
  logic [31:0] seed = 32'd40154;
  logic [9:0]  code = 10'h000;
  sar_adc_config_window_compare i_sar_adc_config_window_compare
  (
    .core_clk_in, .reset_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in,
    .lfo_tick_in, .sar_cmp_in, .sfr_rdata_out, .low_power_out, .gain_unity_out,
    .tracking_out, .busy_out, .sar_trial_out, .conv_tick_out, .window_flag_out
  );
  initial
  begin
    forever #10 core_clk_in = ~core_clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one idle edge after each access keeps a strobe from being set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in  <= a;
    sfr_wdata_in <= d;
    sfr_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    sfr_wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    sfr_addr_in <= a;
    sfr_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    sfr_rd_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  // comparator answers as an ideal input at code; lfo ticks every other cycle
  always @(posedge core_clk_in)
  begin
    sar_cmp_in  <= (sar_trial_out <= code);
    lfo_tick_in <= ~lfo_tick_in;
  end
  always @(posedge core_clk_in)
  begin
    if (rd_seen)
    begin
      exp_v = exp_q.pop_front();
      `CHK(sfr_rdata_out, exp_v)
    end
    rd_seen <= sfr_rd_in;
  end
  initial
  begin
    logic [31:0] r;
    logic [15:0] gt, lt, w;
    logic [7:0]  ctl, cfg;
    logic        hit;
    int          n;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rd(`SAR_OFS_CONFIG, `SAR_CONFIG_RESET);
    rd(`SAR_OFS_LT_LOW, 8'h00);
    rd(`SAR_OFS_LT_HIGH, 8'h00);
    rd(8'h00, 8'h00);
    wr(`SAR_OFS_LT_HIGH, 8'hA5);
    rd(`SAR_OFS_LT_HIGH, 8'hA5);
    for (int p = 1; p >= 0; p--)
    begin
      wr(`SAR_OFS_POWER, {p[0], 7'h00});
      @(posedge core_clk_in);
      `CHK(low_power_out, p[0])
    end
    for (int i = 0; i < 40; i++)
    begin
      r    = rnd();
      code = r[9:0];
      cfg  = {5'h03, r[12:10]};
      ctl  = {1'b0, r[13], r[14], r[15], 4'h0};
      w    = cfg[2] ? {code[9:2], 8'h00} : (ctl[5] ? {code, 6'h00} : {6'h00, code});
      r    = rnd();
      gt   = r[1] ? w : r[15:0];
      lt   = r[2] ? w : r[31:16];
      if (cfg[2])
        lt[7:0] = 8'h00;
      hit  = ctl[6] ? (w < gt || w > lt) : (gt < w && w < lt);
      wr(`SAR_OFS_CONFIG, cfg);
      wr(`SAR_OFS_GT_LOW, gt[7:0]);
      wr(`SAR_OFS_GT_HIGH, gt[15:8]);
      wr(`SAR_OFS_LT_LOW, lt[7:0]);
      wr(`SAR_OFS_LT_HIGH, lt[15:8]);
      `CHK(gain_unity_out, cfg[0])
      wr(`SAR_OFS_CONTROL, ctl);
      wr(`SAR_OFS_CONTROL, ctl | 8'h81);
      for (n = 0; n < 600 && (n < 2 || busy_out !== 1'b0); n++)
        @(posedge core_clk_in);
      if (n == 600)
      begin
        num_errors++;
        break;
      end
      rd(`SAR_OFS_RESULT_HIGH, w[15:8]);
      rd(`SAR_OFS_RESULT_LOW, w[7:0]);
      `CHK(window_flag_out, hit)
    end
    report_and_stop();
  end
endmodule
